// file: hw/pisd_pkg.sv
// shared constants and types of the oscillator input selector and divider
package pisd_pkg;
	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] PISD_IDX_MODE = 8'h21;
	localparam logic [7:0] PISD_IDX_RATIO = 8'h41;
	localparam logic [7:0] PISD_IDX_BUF = 8'h0c;
	localparam logic [7:0] PISD_IDX_XFER = 8'h10;
	localparam logic [7:0] PISD_IDX_STAT = 8'h11;
	localparam int unsigned PISD_ADDR_W = 12;

	// values after reset
	localparam logic [1:0] PISD_MODE_RST = 2'h0;
	localparam logic [15:0] PISD_RATIO_RST = 16'h0000;
	localparam logic [15:0] PISD_BUF_RST = 16'h0000;

	// transfer command bits
	localparam int unsigned PISD_XFER_PUT_BIT = 0;
	localparam int unsigned PISD_XFER_GET_BIT = 1;

	// status bits
	localparam int unsigned PISD_STAT_RUN_BIT = 0;
	localparam int unsigned PISD_STAT_LOW_BIT = 1;
	localparam int unsigned PISD_STAT_HIGH_BIT = 2;
	localparam int unsigned PISD_STAT_SWALLOW_BIT = 3;

	// division-ratio register fields
	localparam int unsigned PISD_PC_LSB = 4;
	localparam int unsigned PISD_SC_W = 4;
	localparam int unsigned PISD_PC_W = 12;

	// prescaler last count for modulus 16 and modulus 17
	localparam logic [4:0] PISD_PRE_LAST_LOW = 5'h0f;
	localparam logic [4:0] PISD_PRE_LAST_HIGH = 5'h10;

	// bus answers
	localparam logic [1:0] PISD_RESP_OKAY = 2'h0;
	localparam logic [1:0] PISD_RESP_SLVERR = 2'h2;

	// division schemes in the order of their two-bit codes
	typedef enum logic [1:0] {
		PISD_INPUTS_OFF,
		PISD_DIRECT_LOW,
		PISD_SWALLOW_HIGH,
		PISD_SWALLOW_LOW
	} pisd_mode_t;
endpackage

// file: hw/pisd_divider.sv
// dual-modulus prescaler, swallow counter and programmable counter
`timescale 1ns/10ps
`default_nettype none
module pisd_divider (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic run,
	input wire logic swallow_mode,
	input wire logic in_edge,
	input wire logic [pisd_pkg::PISD_PC_W-1:0] pc_load,
	input wire logic [pisd_pkg::PISD_SC_W-1:0] sc_load,
	// divided pulse to the phase comparator
	output logic div_out
);
	import pisd_pkg::*;

	logic [4:0] pre_cnt;
	logic [PISD_SC_W-1:0] sc_cnt;
	logic [PISD_PC_W-1:0] pc_cnt;

	// modulus is 17 while swallow counts remain, else 16
	wire pre_last = (sc_cnt != 4'h0) ? (pre_cnt == PISD_PRE_LAST_HIGH)
		: (pre_cnt == PISD_PRE_LAST_LOW);
	// direct division bypasses the prescaler entirely
	wire pc_step = in_edge && (swallow_mode ? pre_last : 1'b1);
	// ratio 0 or 1 is prohibited by software; treated as terminal
	wire pc_term = pc_step && (pc_cnt <= 12'h001);
	wire [PISD_SC_W-1:0] sc_start = swallow_mode ? sc_load : 4'h0;

	// counters reload at terminal count and while run is low, so a new ratio takes effect cleanly
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			pre_cnt <= 5'h00;
			sc_cnt <= sc_start;
			pc_cnt <= pc_load;
			div_out <= 1'b0;
		end else begin
			div_out <= pc_term;
			// a live switch to direct division must not leave a stale prescaler phase
			if (!swallow_mode) begin
				pre_cnt <= 5'h00;
			end else if (in_edge) begin
				pre_cnt <= pre_last ? 5'h00 : pre_cnt + 5'h01;
			end
			if (pc_term) begin
				pc_cnt <= pc_load;
				sc_cnt <= sc_start;
			end else if (pc_step) begin
				pc_cnt <= pc_cnt - 12'h001;
				if (sc_cnt != 4'h0) begin
					sc_cnt <= sc_cnt - 4'h1;
				end
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_reload;
		pc_term |=> (pc_cnt == $past(pc_load));
	endproperty
	a_reload: assert property (p_reload) else $error("counter not reloaded at terminal");

	property p_direct_bypass;
		!swallow_mode |=> (pre_cnt == 5'h00);
	endproperty
	a_direct_bypass: assert property (p_direct_bypass) else $error("prescaler moved in direct");

	property p_mod17;
		(run && swallow_mode && in_edge && sc_cnt != 4'h0 && pre_cnt == PISD_PRE_LAST_LOW)
			|=> (pre_cnt == PISD_PRE_LAST_HIGH);
	endproperty
	a_mod17: assert property (p_mod17) else $error("prescaler not at modulus 17");

	property p_pc_dec;
		(run && pc_step && !pc_term) ##1 run |-> (pc_cnt == $past(pc_cnt) - 12'h001);
	endproperty
	a_pc_dec: assert property (p_pc_dec) else $error("programmable counter did not step");
endmodule
`default_nettype wire

// file: hw/pisd_top.sv
// oscillator input selector and programmable divider with its register slave
//
// How it works
// - divider is a dual-modulus prescaler, swallow counter, programmable counter and switch.
// - mode code 00 off, 01 direct low-band, 10 swallow high-band, 11 swallow low-band.
// - the oscillator pin not chosen by the mode is pulled down.
// - direct division uses only the programmable counter.
// - swallow modes use both counters; swallow counter steers prescaler modulus.
// - mode 00 pulls both pins down while the synthesizer keeps running.
// - the ratio register is loaded only by transfer from the buffer.
// - swallow counter is 4-bit, programmable counter 12-bit, both counting down.
// - upper 12 bits load the programmable counter; lower 4 the swallow counter.
// - the synthesizer runs only while the enable input is high.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module pisd_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic [pisd_pkg::PISD_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// write data channel
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response channel
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address channel
	input wire logic [pisd_pkg::PISD_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// read data channel
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// oscillator pins and system inputs
	input wire logic high_band_osc_input,
	input wire logic low_band_osc_input,
	input wire logic device_enable,
	input wire logic clock_stop_reset,
	// pin pull-down controls and divider outputs
	output logic high_band_pulldown,
	output logic low_band_pulldown,
	output logic synth_run,
	output logic divided_output
);
	import pisd_pkg::*;

	// decoding shared by the write and read paths
	function automatic logic hit(input logic [PISD_ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a[PISD_ADDR_W-1:2] == {2'h0, idx});
	endfunction

	logic aw_held;
	logic w_held;
	logic [PISD_ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [1:0] mode_q;
	logic [15:0] buf_q;
	logic [15:0] ratio_q;
	logic osc_prev;
	logic rd_mode_q;

	// handshake outputs are combinational; one write is held at a time
	assign awready = !aw_held;
	assign wready = !w_held;
	assign arready = !rvalid;

	wire aw_take = awvalid && awready;
	wire w_take = wvalid && wready;
	wire ar_take = arvalid && arready;
	wire do_write = aw_held && w_held && !bvalid;

	// write decode
	wire wr_hit_mode = hit(aw_addr_q, PISD_IDX_MODE);
	wire wr_hit_buf = hit(aw_addr_q, PISD_IDX_BUF);
	wire wr_hit_xfer = hit(aw_addr_q, PISD_IDX_XFER);
	wire wr_mode = do_write && wr_hit_mode && w_strb_q[0];
	wire wr_buf = do_write && wr_hit_buf;
	wire wr_xfer = do_write && wr_hit_xfer && w_strb_q[0];
	// ratio and status are read-only, so a write to them is answered with an error
	wire wr_ok = wr_hit_mode || wr_hit_buf || wr_hit_xfer;
	wire do_put = wr_xfer && w_data_q[PISD_XFER_PUT_BIT];
	wire do_get = wr_xfer && w_data_q[PISD_XFER_GET_BIT];

	// mode decode
	pisd_mode_t cur_mode;
	assign cur_mode = pisd_mode_t'(mode_q);
	wire sel_high = (cur_mode == PISD_SWALLOW_HIGH);
	wire sel_low = (cur_mode == PISD_DIRECT_LOW) || (cur_mode == PISD_SWALLOW_LOW);
	wire swallow = (cur_mode == PISD_SWALLOW_HIGH) || (cur_mode == PISD_SWALLOW_LOW);
	wire div_run = device_enable && (cur_mode != PISD_INPUTS_OFF);

	// a pulled-down pin contributes no edges
	wire osc_sel = (sel_high && high_band_osc_input) || (sel_low && low_band_osc_input);
	wire osc_edge = osc_sel && !osc_prev;

	// read decode
	wire rd_hit_mode = hit(araddr, PISD_IDX_MODE);
	wire rd_hit_ratio = hit(araddr, PISD_IDX_RATIO);
	wire rd_hit_buf = hit(araddr, PISD_IDX_BUF);
	wire rd_hit_xfer = hit(araddr, PISD_IDX_XFER);
	wire rd_hit_stat = hit(araddr, PISD_IDX_STAT);
	wire rd_ok = rd_hit_mode || rd_hit_ratio || rd_hit_buf || rd_hit_xfer || rd_hit_stat;
	wire [3:0] stat_bits = {swallow, sel_high, sel_low, synth_run};
	wire [31:0] rd_value = rd_hit_mode ? {28'h0000000, 2'h0, mode_q}
		: rd_hit_ratio ? {16'h0000, ratio_q}
		: rd_hit_buf ? {16'h0000, buf_q}
		: rd_hit_stat ? {28'h0000000, stat_bits}
		: 32'h00000000;

	// address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr_q <= 12'h000;
		end else if (aw_take) begin
			aw_held <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (w_take) begin
			w_held <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// write response follows one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= PISD_RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? PISD_RESP_OKAY : PISD_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// read data is registered at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= PISD_RESP_OKAY;
			rd_mode_q <= 1'b0;
		end else if (ar_take) begin
			rvalid <= 1'b1;
			rdata <= rd_value;
			rresp <= rd_ok ? PISD_RESP_OKAY : PISD_RESP_SLVERR;
			rd_mode_q <= rd_hit_mode;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// clock stop beats a software write; the enable input never touches the mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= PISD_MODE_RST;
		end else if (clock_stop_reset) begin
			mode_q <= PISD_MODE_RST;
		end else if (wr_mode) begin
			mode_q <= w_data_q[1:0];
		end
	end

	// transfer buffer, byte lanes 0 and 1; a get copies the ratio back
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_q <= PISD_BUF_RST;
		end else if (do_get) begin
			buf_q <= ratio_q;
		end else if (wr_buf) begin
			if (w_strb_q[0]) begin
				buf_q[7:0] <= w_data_q[7:0];
			end
			if (w_strb_q[1]) begin
				buf_q[15:8] <= w_data_q[15:8];
			end
		end
	end

	// the counters only ever see a ratio that came through the buffer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ratio_q <= PISD_RATIO_RST;
		end else if (do_put) begin
			ratio_q <= buf_q;
		end
	end

	// pin controls; both pins pulled down while in reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_band_pulldown <= 1'b1;
			low_band_pulldown <= 1'b1;
			synth_run <= 1'b0;
			osc_prev <= 1'b0;
		end else begin
			high_band_pulldown <= !sel_high;
			low_band_pulldown <= !sel_low;
			synth_run <= device_enable;
			osc_prev <= osc_sel;
		end
	end

	// swallow count never exceeds the programmable count for legal ratios
	pisd_divider u_divider (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(div_run),
		.swallow_mode(swallow),
		.in_edge(osc_edge),
		.pc_load(ratio_q[15:PISD_PC_LSB]),
		.sc_load(ratio_q[PISD_SC_W-1:0]),
		.div_out(divided_output)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_pin_high;
		(mode_q == 2'h2) |=> (!high_band_pulldown && low_band_pulldown);
	endproperty
	a_pin_high: assert property (p_pin_high) else $error("high band pin not selected");

	property p_pin_low;
		mode_q[0] |=> (high_band_pulldown && !low_band_pulldown);
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("low band pin not selected");

	property p_off_running;
		(mode_q == 2'h0 && device_enable) |=> (high_band_pulldown && low_band_pulldown && synth_run);
	endproperty
	a_off_running: assert property (p_off_running) else $error("off mode stopped synth");

	property p_clock_stop;
		clock_stop_reset |=> (mode_q == 2'h0);
	endproperty
	a_clock_stop: assert property (p_clock_stop) else $error("clock stop left mode set");

	property p_enable_keeps;
		(!device_enable && !wr_mode && !clock_stop_reset) |=> $stable(mode_q);
	endproperty
	a_enable_keeps: assert property (p_enable_keeps) else $error("enable low changed mode");

	property p_fixed_bits;
		(rvalid && rd_mode_q) |-> (rdata[31:2] == 30'h00000000);
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("mode upper bits not zero");

	property p_ratio_xfer;
		!$stable(ratio_q) |-> $past(do_put);
	endproperty
	a_ratio_xfer: assert property (p_ratio_xfer) else $error("ratio changed without put");

	property p_disabled;
		!device_enable [*2] |-> !divided_output;
	endproperty
	a_disabled: assert property (p_disabled) else $error("divider ran while disabled");
endmodule
`default_nettype wire

// file: tb/pisd_osc_model.sv
// behavioural oscillator that feeds both band pins of the divider
`timescale 1ns/10ps
`default_nettype none
module pisd_osc_model (
	// clock and control from the bench
	input wire logic aclk,
	input wire logic run,
	input wire logic slow,
	// pull-down state of each pin
	input wire logic high_band_pulldown,
	input wire logic low_band_pulldown,
	// pin levels seen by the divider
	output logic high_band_osc_input,
	output logic low_band_osc_input
);
	logic osc = 1'b0;
	logic [1:0] cnt = 2'h0;
	// half period of one or three cycles, so rising edges never come closer than two cycles
	always @(posedge aclk) begin
		if (!run || cnt == (slow ? 2'h2 : 2'h0)) begin
			cnt <= 2'h0;
			osc <= run & ~osc;
		end else begin
			cnt <= cnt + 2'h1;
		end
	end
	// a pulled-down pin sits at its pull level, not at the last driven value
	assign high_band_osc_input = osc & ~high_band_pulldown;
	assign low_band_osc_input = osc & ~low_band_pulldown;
endmodule
`default_nettype wire

// file: tb/tb_pisd_top.sv
// self-checking testbench of the oscillator input selector and divider
`timescale 1ns/10ps
`default_nettype none
module tb_pisd_top;
	import pisd_pkg::*;
	localparam logic [11:0] A_MODE = {2'h0, PISD_IDX_MODE, 2'h0};
	localparam logic [11:0] A_RATIO = {2'h0, PISD_IDX_RATIO, 2'h0};
	localparam logic [11:0] A_BUF = {2'h0, PISD_IDX_BUF, 2'h0};
	localparam logic [11:0] A_XFER = {2'h0, PISD_IDX_XFER, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, PISD_IDX_STAT, 2'h0};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
	logic device_enable = 1'b0, clock_stop_reset = 1'b0, osc_run = 1'b0, osc_slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, synth_run, divided_output;
	logic high_band_osc_input, low_band_osc_input, high_band_pulldown, low_band_pulldown;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic mon_on = 1'b0, exp_pulse = 1'b0, prev = 1'b0, sel;
	int n_fail = 0, tests_run = 0, m_mode = 0, m_ratio = 0, n_exp = 1, cnt = 0, n_pulse = 0;
	int unsigned rng = 81966;

	initial begin
		forever #2.5 aclk = ~aclk;
	end

	pisd_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .high_band_osc_input, .low_band_osc_input, .device_enable, .clock_stop_reset,
		.high_band_pulldown, .low_band_pulldown, .synth_run, .divided_output);

	pisd_osc_model osc (.aclk, .run(osc_run), .slow(osc_slow), .high_band_pulldown,
		.low_band_pulldown, .high_band_osc_input, .low_band_osc_input);

	// pin that the current mode should feed to the divider
	assign sel = (m_mode == 2) ? high_band_osc_input : ((m_mode != 0) ? low_band_osc_input : 1'b0);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic tally_and_finish;
		if (n_fail == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic int unsigned xs(input int unsigned x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	// one write; bready stays high so bvalid seen at an edge is the handshake
	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (i = 0; i < 50 && !bvalid; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		if (i == 50) n_fail++;
		if (i == 50) tally_and_finish();
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		for (i = 0; i < 50 && !rvalid; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end
		if (i == 50) n_fail++;
		if (i == 50) tally_and_finish();
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// reference divider: counts rising edges of the selected pin, pulse the cycle after the nth
	always @(posedge aclk) begin
		if (mon_on) chk({31'h0, divided_output}, {31'h0, exp_pulse});
		exp_pulse = 1'b0;
		if (sel && !prev) cnt++;
		if (cnt == n_exp) begin
			exp_pulse = 1'b1;
			cnt = 0;
			n_pulse++;
		end
		prev = sel;
	end

	initial begin
		int md, r, i;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axr(A_MODE, 32'h0, PISD_RESP_OKAY);
		axr(A_RATIO, 32'h0, PISD_RESP_OKAY);
		axr(12'h200, 32'h0, PISD_RESP_SLVERR);
		axw(12'h200, 32'h5, PISD_RESP_SLVERR);
		axw(A_MODE, 32'hf, PISD_RESP_OKAY);
		axr(A_MODE, 32'h3, PISD_RESP_OKAY);
		clock_stop_reset <= 1'b1;
		@(posedge aclk);
		clock_stop_reset <= 1'b0;
		axr(A_MODE, 32'h0, PISD_RESP_OKAY);
		axw(A_MODE, 32'h2, PISD_RESP_OKAY);
		device_enable <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({31'h0, synth_run}, 32'h1);
		device_enable <= 1'b0;
		repeat (3) @(posedge aclk);
		chk({31'h0, synth_run}, 32'h0);
		axr(A_MODE, 32'h2, PISD_RESP_OKAY);
		axw(A_RATIO, 32'h1234, PISD_RESP_SLVERR);
		axr(A_RATIO, 32'h0, PISD_RESP_OKAY);
		axw(A_BUF, 32'hbeef, PISD_RESP_OKAY);
		axw(A_XFER, 32'h1, PISD_RESP_OKAY);
		axw(A_BUF, 32'h0, PISD_RESP_OKAY);
		axw(A_XFER, 32'h2, PISD_RESP_OKAY);
		axr(A_BUF, 32'hbeef, PISD_RESP_OKAY);
		axr(A_RATIO, 32'hbeef, PISD_RESP_OKAY);
		axr(A_XFER, 32'h0, PISD_RESP_OKAY);
		// byte lanes: lane 1 only into the buffer, then a mode write with no lane at all
		wstrb <= 4'h2;
		axw(A_BUF, 32'h1200, PISD_RESP_OKAY);
		wstrb <= 4'h0;
		axw(A_MODE, 32'h3, PISD_RESP_OKAY);
		wstrb <= 4'hf;
		axr(A_BUF, 32'h12ef, PISD_RESP_OKAY);
		axr(A_MODE, 32'h2, PISD_RESP_OKAY);
		// every mode code, fast and slow oscillator, divider idle while it is set up
		for (int k = 0; k < 4; k++) begin
			md = (k + 1) % 4;
			rng = xs(rng);
			r = (md == 1) ? ((16 + rng % 32) << 4) | (rng & 15) : 256 + rng % 64;
			axw(A_MODE, 32'(md), PISD_RESP_OKAY);
			axw(A_BUF, 32'(r), PISD_RESP_OKAY);
			axw(A_XFER, 32'h1, PISD_RESP_OKAY);
			axr(A_RATIO, 32'(r), PISD_RESP_OKAY);
			axr(A_STAT, {28'h0, md[1], md == 2, md[0], 1'b0}, PISD_RESP_OKAY);
			device_enable <= 1'b1;
			repeat (3) @(posedge aclk);
			chk({high_band_pulldown, low_band_pulldown, synth_run}, {md != 2, md % 2 == 0, 1'b1});
			@(negedge aclk);
			m_mode = md;
			n_exp = (md == 1) ? r >> 4 : r;
			cnt = 0;
			n_pulse = 0;
			mon_on = 1'b1;
			@(posedge aclk);
			osc_slow <= k[0];
			osc_run <= 1'b1;
			for (i = 0; i < 20000 && (md == 0 ? i < 400 : n_pulse < 2); i++) @(posedge aclk);
			if (i == 20000) begin
				n_fail++;
				tally_and_finish();
			end
			repeat (3) @(posedge aclk);
			@(negedge aclk);
			mon_on = 1'b0;
			@(posedge aclk);
			osc_run <= 1'b0;
			device_enable <= 1'b0;
			repeat (4) @(posedge aclk);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
